// ===== osg_pkg.sv
// Overview of operation
// - bit 0 flags calibration mode
// - bit 5 flags waiting for trigger
// - bit 8 flags constant-voltage regulation
// - bit 10 flags constant-current regulation
// - bit 11 flags turn-on delay active
// - bit 12 flags turn-off delay active
// - bit 14 flags test program running
// - condition word mirrors live status continuously
// - condition read has no side effect
// - enabled rising filter latches false-to-true changes
// - enabled falling filter latches true-to-false changes
// - events set only by selected same-position transitions
// - event read returns value then clears all except events set in the read cycle
// - mask selects events feeding the summary bit
// - summary appears as status byte bit 7
package osg_pkg;

    // ****************************************************************
    // word layout
    // ****************************************************************
    localparam int unsigned OSG_WIDTH = 16;

    localparam int unsigned BIT_CALIBRATION  = 0;
    localparam int unsigned BIT_TRIGGER_WAIT = 5;
    localparam int unsigned BIT_VOLTAGE_REG  = 8;
    localparam int unsigned BIT_CURRENT_REG  = 10;
    localparam int unsigned BIT_TURN_ON_DLY  = 11;
    localparam int unsigned BIT_TURN_OFF_DLY = 12;
    localparam int unsigned BIT_PROGRAM_RUN  = 14;
    localparam int unsigned STB_SUMMARY_BIT  = 7;

    // implemented condition bits
    localparam logic [15:0] COND_IMPL_MASK = 16'h5D21;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_CONDITION  = 8'h00;
    localparam logic [7:0] OFS_RISE_FILT  = 8'h04;
    localparam logic [7:0] OFS_FALL_FILT  = 8'h08;
    localparam logic [7:0] OFS_EVENTS     = 8'h0C;
    localparam logic [7:0] OFS_SUM_MASK   = 8'h10;
    localparam logic [7:0] OFS_STATUS_BYTE = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;

    // reset values
    localparam logic [15:0] RST_RISE_FILT = 16'hFFFF;
    localparam logic [15:0] RST_FALL_FILT = 16'h0000;
    localparam logic [15:0] RST_SUM_MASK  = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK  = 16'h0000;

    // ahb transfer types
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // live status inputs
    typedef struct packed {
        logic calibration;
        logic trigger_wait;
        logic voltage_regulating;
        logic current_regulating;
        logic turn_on_delay_active;
        logic turn_off_delay_active;
        logic test_program_running;
    } osg_status_s;

    // captured address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } osg_aphase_s;

endpackage

// ===== osg_operation_status_group.sv
`timescale 1ns/1ps
module osg_operation_status_group
    import osg_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               srst_i,
    // live status from the supply (asynchronous)
    input  wire osg_status_s        status_i,
    // ahb-lite slave
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic [31:0]             hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    // summary and interrupt
    output logic                    operation_summary_o,
    output logic                    irq_o
);

    // ****************************************************************
    // condition word
    // ****************************************************************
    logic [15:0] raw_cond;
    logic [15:0] sync1_q;
    logic [15:0] cond_q;
    logic [15:0] cond_prev_q;

    // pack the live status into its bit positions
    always_comb
    begin
        raw_cond                   = 16'h0000;
        raw_cond[BIT_CALIBRATION]  = status_i.calibration;
        raw_cond[BIT_TRIGGER_WAIT] = status_i.trigger_wait;
        raw_cond[BIT_VOLTAGE_REG]  = status_i.voltage_regulating;
        raw_cond[BIT_CURRENT_REG]  = status_i.current_regulating;
        raw_cond[BIT_TURN_ON_DLY]  = status_i.turn_on_delay_active;
        raw_cond[BIT_TURN_OFF_DLY] = status_i.turn_off_delay_active;
        raw_cond[BIT_PROGRAM_RUN]  = status_i.test_program_running;
    end

    // two-stage synchroniser, then a copy for edge detection
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sync1_q     <= 16'h0000;
            cond_q      <= 16'h0000;
            cond_prev_q <= 16'h0000;
        end
        else
        begin
            sync1_q     <= raw_cond;
            cond_q      <= sync1_q;
            cond_prev_q <= cond_q;
        end
    end

    // ****************************************************************
    // bus address phase capture
    // ****************************************************************
    osg_aphase_s ap_q;
    wire         ap_take = hsel_i & hready_i & htrans_i[1];

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            ap_q <= '0;
        end
        else if (hready_i)
        begin
            ap_q <= '{valid: ap_take, write: hwrite_i, addr: haddr_i[7:0]};
        end
    end

    // data phase strobes, zero wait state
    wire wr_en       = ap_q.valid & ap_q.write;
    wire rd_en       = ap_q.valid & ~ap_q.write;
    wire wr_rise     = wr_en & (ap_q.addr == OFS_RISE_FILT);
    wire wr_fall     = wr_en & (ap_q.addr == OFS_FALL_FILT);
    wire wr_smask    = wr_en & (ap_q.addr == OFS_SUM_MASK);
    wire wr_istat    = wr_en & (ap_q.addr == OFS_IRQ_STATUS);
    wire wr_imask    = wr_en & (ap_q.addr == OFS_IRQ_MASK);
    wire rd_events   = rd_en & (ap_q.addr == OFS_EVENTS);

    // ****************************************************************
    // filters, mask and event latch
    // ****************************************************************
    logic [15:0] rise_filt_q;
    logic [15:0] fall_filt_q;
    logic [15:0] sum_mask_q;
    logic [15:0] events_q;

    wire [15:0] rose_bits = cond_q & ~cond_prev_q;
    wire [15:0] fell_bits = ~cond_q & cond_prev_q;
    // only selected transitions at the same position set events
    wire [15:0] ev_set = (rose_bits & rise_filt_q)
                       | (fell_bits & fall_filt_q);

    // control registers written by software
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            rise_filt_q <= RST_RISE_FILT;
            fall_filt_q <= RST_FALL_FILT;
            sum_mask_q  <= RST_SUM_MASK;
        end
        else
        begin
            if (wr_rise)  rise_filt_q <= hwdata_i[15:0];
            if (wr_fall)  fall_filt_q <= hwdata_i[15:0];
            if (wr_smask) sum_mask_q  <= hwdata_i[15:0];
        end
    end

    // events hold until read; a new event in the read cycle survives
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            events_q <= 16'h0000;
        end
        else if (rd_events)
        begin
            events_q <= ev_set;
        end
        else
        begin
            events_q <= events_q | ev_set;
        end
    end

    // summary is combinational from the latched events
    assign operation_summary_o = |(events_q & sum_mask_q);

    wire [7:0] status_byte = {operation_summary_o, 7'h00};

    // ****************************************************************
    // interrupt: bit 0 new event, bit 1 summary rose
    // ****************************************************************
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic       summary_prev_q;
    wire  [1:0] irq_set = {operation_summary_o & ~summary_prev_q, |ev_set};

    // sticky status, write one to clear, set wins
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            irq_stat_q     <= 2'h0;
            irq_mask_q     <= RST_IRQ_MASK[1:0];
            summary_prev_q <= 1'b0;
        end
        else
        begin
            irq_stat_q     <= (irq_stat_q & ~(wr_istat ? hwdata_i[1:0] : 2'h0)) | irq_set;
            summary_prev_q <= operation_summary_o;
            if (wr_imask) irq_mask_q <= hwdata_i[1:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [31:0] rd_mux;

    // condition read is a plain view, no side effect
    always_comb
    begin
        case (ap_q.addr)
            OFS_CONDITION:   rd_mux = {16'h0000, cond_q};
            OFS_RISE_FILT:   rd_mux = {16'h0000, rise_filt_q};
            OFS_FALL_FILT:   rd_mux = {16'h0000, fall_filt_q};
            OFS_EVENTS:      rd_mux = {16'h0000, events_q};
            OFS_SUM_MASK:    rd_mux = {16'h0000, sum_mask_q};
            OFS_STATUS_BYTE: rd_mux = {24'h000000, status_byte};
            OFS_IRQ_STATUS:  rd_mux = {30'h0, irq_stat_q};
            OFS_IRQ_MASK:    rd_mux = {30'h0, irq_mask_q};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    assign hrdata_o    = rd_en ? rd_mux : 32'h00000000;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

endmodule // osg_operation_status_group

// ===== osg_operation_status_group_asserts.sv
`timescale 1ns/1ps
module osg_operation_status_group_asserts
    import osg_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    // watched ports
    input wire osg_status_s status_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        operation_summary_o
);
    // ********
    // helpers
    // ********
    // accepted transfer and expected condition word
    wire        take_w = hsel_i && hready_i && htrans_i[1];
    wire osg_status_s s = status_i;
    wire [15:0] cond_w = {1'b0, s.test_program_running, 1'b0, s.turn_off_delay_active, s.turn_on_delay_active,
                          s.current_regulating, 1'b0, s.voltage_regulating, 2'h0, s.trigger_wait, 4'h0, s.calibration};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // read address phase at one offset
    sequence rd_at(logic [7:0] a);
        take_w && !hwrite_i && haddr_i[7:0] == a;
    endsequence
    // ********
    // checks
    // ********
    a_ready_high: assert property (hreadyout_o) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp_o) else $error("response not okay");
    a_idle_zero: assert property (!take_w |=> hrdata_o == 32'h0) else $error("idle read data");
    a_upper_zero: assert property (take_w && !hwrite_i |=> hrdata_o[31:16] == 16'h0) else $error("upper bits");
    a_unmapped_zero: assert property (take_w && !hwrite_i && haddr_i[7:0] > 8'h1F |=> hrdata_o == 32'h0)
        else $error("unmapped read");
    a_stb_summary: assert property (rd_at(OFS_STATUS_BYTE) |=> hrdata_o == {24'h0, operation_summary_o, 7'h0})
        else $error("status byte");
    a_cond_mirror: assert property ($stable(status_i)[*3] ##0 rd_at(OFS_CONDITION) |=> hrdata_o[15:0] == $past(cond_w))
        else $error("condition word");
    a_event_clear: assert property ($stable(status_i)[*5] ##0 rd_at(OFS_EVENTS) ##2 rd_at(OFS_EVENTS)
        |=> hrdata_o == 32'h0) else $error("events not cleared");
endmodule // osg_operation_status_group_asserts

bind osg_operation_status_group osg_operation_status_group_asserts osg_operation_status_group_asserts_i (.ref_clk_i,
    .srst_i, .status_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .operation_summary_o);

// ===== osg_operation_status_group_bench.sv
`timescale 1ns/1ps
module osg_operation_status_group_bench
    import osg_pkg::*;
;
    typedef struct packed {logic [15:0] rise, fall, mask; osg_status_s from, to; logic [15:0] ev; logic sum;} osg_row_s;
    // ********
    // stimulus table
    // ********
    localparam osg_row_s ROWS [5] = '{
        '{16'hFFFF, 16'h0000, 16'hFFFF, 7'h00, 7'h7F, 16'h5D21, 1'b1},
        '{16'h0000, 16'hFFFF, 16'h0000, 7'h7F, 7'h00, 16'h5D21, 1'b0},
        '{16'h0001, 16'h0000, 16'h0001, 7'h00, 7'h7F, 16'h0001, 1'b1},
        '{16'h0000, 16'h4000, 16'h0020, 7'h7F, 7'h00, 16'h4000, 1'b0},
        '{16'h0000, 16'h0000, 16'hFFFF, 7'h00, 7'h7F, 16'h0000, 1'b0}};
    logic        ref_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    osg_status_s status_i = '0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [31:0] haddr_i = '0;
    logic [31:0] hwdata_i = '0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [31:0] hrdata_o, rd_q;
    logic        hreadyout_o, hresp_o, operation_summary_o, irq_o;
    int          fail_count = 0;
    int          total_checks = 0;

    // free running clock
    always #25 ref_clk_i = ~ref_clk_i;

    osg_operation_status_group osg_operation_status_group_i (.ref_clk_i, .srst_i, .status_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
        .operation_summary_o, .irq_o);

    // ********
    // tasks
    // ********
    task stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready at a rising edge
    task wait_rdy;
        int n;
        n = 0;
        @(posedge ref_clk_i);
        while (hreadyout_o !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                fail_count++;
                stop_test;
            end
            @(posedge ref_clk_i);
        end
    endtask
    // one single word transfer, address phase then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel_i <= 1'b1;
        htrans_i <= HTRANS_NONSEQ;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        wait_rdy;
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_rdy;
        rd_q = hrdata_o;
    endtask
    // status change needs three edges to latch
    task drive(input osg_status_s v);
        status_i <= v;
        repeat (4) @(posedge ref_clk_i);
    endtask
    function automatic logic [31:0] cmap(input osg_status_s s);
        return {17'h0, s.test_program_running, 1'b0, s.turn_off_delay_active, s.turn_on_delay_active,
                s.current_regulating, 1'b0, s.voltage_regulating, 2'h0, s.trigger_wait, 4'h0, s.calibration};
    endfunction

    // ********
    // sequence
    // ********
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        foreach (ROWS[i])
        begin
            bus(1'b1, OFS_RISE_FILT, {16'h0, ROWS[i].rise});
            bus(1'b1, OFS_FALL_FILT, {16'h0, ROWS[i].fall});
            bus(1'b1, OFS_SUM_MASK, {16'h0, ROWS[i].mask});
            drive(ROWS[i].from);
            bus(1'b0, OFS_EVENTS, 32'h0);
            drive(ROWS[i].to);
            repeat (2)
            begin
                bus(1'b0, OFS_CONDITION, 32'h0);
                chk(rd_q, cmap(ROWS[i].to));
            end
            drive(ROWS[i].from);
            chk({31'h0, operation_summary_o}, {31'h0, ROWS[i].sum});
            bus(1'b0, OFS_STATUS_BYTE, 32'h0);
            chk(rd_q, {24'h0, ROWS[i].sum, 7'h0});
            bus(1'b0, OFS_EVENTS, 32'h0);
            chk(rd_q, {16'h0, ROWS[i].ev});
            bus(1'b0, OFS_EVENTS, 32'h0);
            chk(rd_q, 32'h0);
            chk({31'h0, operation_summary_o}, 32'h0);
        end
        // interrupt raised, cleared, then masked
        bus(1'b1, OFS_IRQ_STATUS, 32'h3);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        bus(1'b1, OFS_RISE_FILT, 32'hFFFF);
        bus(1'b1, OFS_FALL_FILT, 32'hFFFF);
        drive(7'h7F);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'b1, OFS_IRQ_STATUS, 32'h3);
        // the clear lands at the closing edge of the data phase
        @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        drive(7'h00);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk(rd_q & 32'h1, 32'h1);
        // unmapped read and read-only write
        bus(1'b0, 8'h40, 32'h0);
        chk(rd_q, 32'h0);
        bus(1'b1, OFS_CONDITION, 32'hFFFF);
        bus(1'b0, OFS_CONDITION, 32'h0);
        chk(rd_q, 32'h0);
        // second reset restores defaults
        srst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        chk({31'h0, operation_summary_o}, 32'h0);
        bus(1'b0, OFS_RISE_FILT, 32'h0);
        chk(rd_q, {16'h0, RST_RISE_FILT});
        bus(1'b0, OFS_FALL_FILT, 32'h0);
        chk(rd_q, {16'h0, RST_FALL_FILT});
        bus(1'b0, OFS_SUM_MASK, 32'h0);
        chk(rd_q, {16'h0, RST_SUM_MASK});
        stop_test;
    end
endmodule // osg_operation_status_group_bench
